// File: include/bsic_regs.svh
`ifndef BSIC_REGS_SVH
`define BSIC_REGS_SVH

// internal clock period
`define BSIC_CLK_NS 20
// steady clock level that resets the dll
`define BSIC_KSTOP_NS 30
`define BSIC_KSTOP_CYC ((`BSIC_KSTOP_NS + `BSIC_CLK_NS - 1) / `BSIC_CLK_NS)
// least low time of the dll disable pin
`define BSIC_DOFF_LOW_NS 40
`define BSIC_DOFF_LOW_CYC \
  ((`BSIC_DOFF_LOW_NS + `BSIC_CLK_NS - 1) / `BSIC_CLK_NS)
// dll lock interval in input clock rising edges
`define BSIC_LOCK_KCYC 2048
// counter widths
`define BSIC_LOCK_CW 12
`define BSIC_STOP_CW 3
`define BSIC_LOW_CW 4
// command to first beat, in true clock rising edges
`define BSIC_RD_LAT 2
`define BSIC_WR_LAT 1
// bus widths
`define BSIC_AW 19
`define BSIC_DW 36
`define BSIC_NBYTE 4
// positions in the synchronised pin vector
`define BSIC_PIN_K 0
`define BSIC_PIN_KB 1
`define BSIC_PIN_OFF 2
`define BSIC_PIN_RD 3
`define BSIC_PIN_WR 4
`define BSIC_PIN_SA 5
`define BSIC_PIN_D (`BSIC_PIN_SA + `BSIC_AW)
`define BSIC_PIN_BW (`BSIC_PIN_D + `BSIC_DW)
`define BSIC_PIN_W (`BSIC_PIN_BW + `BSIC_NBYTE)

`endif

// File: include/bsic_pkg.sv
`include "bsic_regs.svh"

package bsic_pkg;
  typedef logic [`BSIC_AW-1:0]    bsic_addr_t;
  typedef logic [`BSIC_DW-1:0]    bsic_data_t;
  typedef logic [`BSIC_NBYTE-1:0] bsic_be_t;
  typedef enum logic [1:0] {
    BSIC_DLL_RST     = 2'h0,
    BSIC_DLL_LOCKING = 2'h1,
    BSIC_DLL_LOCKED  = 2'h2,
    BSIC_DLL_BYPASS  = 2'h3
  } bsic_dll_t;
endpackage

// File: include/bsic_burst_if.sv
interface bsic_burst_if;
  import bsic_pkg::*;
  logic       k_rise;
  logic       kb_rise;
  logic       cmd;
  bsic_addr_t base;
  logic       take;
  logic       beat;
  logic [1:0] idx;
  bsic_addr_t addr;
  modport core (output k_rise, kb_rise, cmd, base,
                input  take, beat, idx, addr);
  modport seq  (input  k_rise, kb_rise, cmd, base,
                output take, beat, idx, addr);
endinterface

// File: logic/bsic_dll_lock.sv
`include "bsic_regs.svh"

module bsic_dll_lock (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  // synchronised pins
  input  wire logic k_s_i,
  input  wire logic kb_s_i,
  input  wire logic k_rise_i,
  input  wire logic dll_off_n_s_i,
  // status
  output logic      ready_o,
  output logic      bypass_o,
  output logic      stop_o
);
  import bsic_pkg::*;

  localparam logic [`BSIC_LOCK_CW-1:0] LOCK_LAST =
    `BSIC_LOCK_CW'(`BSIC_LOCK_KCYC - 1);
  localparam logic [`BSIC_STOP_CW-1:0] STOP_CYC =
    `BSIC_STOP_CW'(`BSIC_KSTOP_CYC);
  localparam logic [`BSIC_LOW_CW-1:0]  LOW_CYC =
    `BSIC_LOW_CW'(`BSIC_DOFF_LOW_CYC);

  typedef struct packed {
    bsic_dll_t                state;
    logic [`BSIC_LOCK_CW-1:0] cnt;
    logic [`BSIC_STOP_CW-1:0] stop_cnt;
    logic [`BSIC_LOW_CW-1:0]  low_cnt;
    logic                     k_prev;
    logic                     kb_prev;
    logic                     off_prev;
  } bsic_lock_st_t;

  bsic_lock_st_t st_ff;
  bsic_lock_st_t nxt_st;
  logic          steady;
  logic          stopped;
  logic          off_rise;
  logic          off_long;

  // either clock pin frozen counts toward a stop
  assign steady   = (k_s_i == st_ff.k_prev) || (kb_s_i == st_ff.kb_prev);
  assign stopped  = st_ff.stop_cnt >= STOP_CYC;
  assign off_rise = dll_off_n_s_i & ~st_ff.off_prev;
  assign off_long = st_ff.low_cnt >= LOW_CYC;
  assign ready_o  = (st_ff.state == BSIC_DLL_LOCKED) ||
                    (st_ff.state == BSIC_DLL_BYPASS);
  assign bypass_o = st_ff.state == BSIC_DLL_BYPASS;
  assign stop_o   = stopped;

  // lock sequencer
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.k_prev   = k_s_i;
    nxt_st.kb_prev  = kb_s_i;
    nxt_st.off_prev = dll_off_n_s_i;
    nxt_st.stop_cnt = steady ? (stopped ? st_ff.stop_cnt
                                        : st_ff.stop_cnt + 1'b1)
                             : '0;
    // short low glitches on the disable pin are filtered out while locking or locked
    nxt_st.low_cnt  = dll_off_n_s_i ? '0 : (off_long ? st_ff.low_cnt
                                                     : st_ff.low_cnt + 1'b1);
    case (st_ff.state)
      BSIC_DLL_RST: begin
        if (!dll_off_n_s_i) begin
          nxt_st.state = BSIC_DLL_BYPASS;
        end else if (!stopped) begin
          nxt_st.state = BSIC_DLL_LOCKING;
          nxt_st.cnt   = '0;
        end
      end
      BSIC_DLL_LOCKING: begin
        if (off_long) begin
          nxt_st.state = BSIC_DLL_BYPASS;
        end else if (stopped) begin
          nxt_st.state = BSIC_DLL_RST;
        end else if (k_rise_i) begin
          // only rising edges of the true clock count
          if (st_ff.cnt == LOCK_LAST) begin
            nxt_st.state = BSIC_DLL_LOCKED;
          end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
          end
        end
      end
      BSIC_DLL_LOCKED: begin
        if (off_long) begin
          nxt_st.state = BSIC_DLL_BYPASS;
        end else if (stopped) begin
          nxt_st.state = BSIC_DLL_RST;
        end
      end
      BSIC_DLL_BYPASS: begin
        if (off_rise) begin
          nxt_st.state = BSIC_DLL_LOCKING;
          nxt_st.cnt   = '0;
        end
      end
      default: nxt_st.state = BSIC_DLL_RST;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_lock_done;
    st_ff.state == BSIC_DLL_LOCKING && k_rise_i && !stopped &&
      !off_long && st_ff.cnt == LOCK_LAST |=> ready_o && !bypass_o;
  endproperty
  a_lock_done: assert property (p_lock_done)
    else $error("lock interval end did not give ready");

  property p_skip_lock;
    st_ff.state == BSIC_DLL_RST && !dll_off_n_s_i |=> bypass_o && ready_o;
  endproperty
  a_skip_lock: assert property (p_skip_lock)
    else $error("disable low did not bypass locking");

  property p_stop_reset;
    stop_o && !bypass_o && !off_long |=> !ready_o;
  endproperty
  a_stop_reset: assert property (p_stop_reset)
    else $error("stopped clock did not reset the dll");

  property p_off_relock;
    bypass_o && off_rise |=> !ready_o && st_ff.cnt == '0;
  endproperty
  a_off_relock: assert property (p_off_relock)
    else $error("disable rise did not restart locking");
endmodule // bsic_dll_lock

// File: logic/bsic_burst_seq.sv
module bsic_burst_seq #(
  parameter int LAT = 2
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  // command and beat side
  bsic_burst_if.seq bus
);
  import bsic_pkg::*;

  localparam int NS = LAT + 2;

  typedef struct packed {
    logic [NS-1:0]       v;
    bsic_addr_t [NS-1:0] a;
    logic                beat;
    logic [1:0]          idx;
    bsic_addr_t          addr;
  } bsic_seq_st_t;

  bsic_seq_st_t st_ff;
  bsic_seq_st_t nxt_st;

  // a command right after an accepted one is dropped
  assign bus.take = bus.k_rise & bus.cmd & ~st_ff.v[0];
  assign bus.beat = st_ff.beat;
  assign bus.idx  = st_ff.idx;
  assign bus.addr = st_ff.addr;

  // pipe advances on true clock rises only, so overlap is free
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.beat = 1'b0;
    if (bus.k_rise) begin
      nxt_st.v = {st_ff.v[NS-2:0], bus.take};
      nxt_st.a = {st_ff.a[NS-2:0], bus.base};
      if (st_ff.v[LAT-1]) begin
        nxt_st.beat = 1'b1;
        nxt_st.idx  = 2'h0;
        nxt_st.addr = st_ff.a[LAT-1];
      end else if (st_ff.v[LAT]) begin
        nxt_st.beat = 1'b1;
        nxt_st.idx  = 2'h2;
        nxt_st.addr = st_ff.a[LAT] + bsic_addr_t'(2'h2);
      end
    end else if (bus.kb_rise) begin
      if (st_ff.v[LAT]) begin
        nxt_st.beat = 1'b1;
        nxt_st.idx  = 2'h1;
        nxt_st.addr = st_ff.a[LAT] + bsic_addr_t'(2'h1);
      end else if (st_ff.v[LAT+1]) begin
        nxt_st.beat = 1'b1;
        nxt_st.idx  = 2'h3;
        nxt_st.addr = st_ff.a[LAT+1] + bsic_addr_t'(2'h3);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // bsic_burst_seq

// File: logic/bsic_core.sv
`include "bsic_regs.svh"

// Function
// - commands wait for the lock interval
// - disable pin low skips dll locking
// - clock frozen over 30 ns resets dll
// - disable pin rising edge resets dll
// - burst addresses base plus zero to three
// - read select low at rise means read
// - write select low at rise means write
// - read and write bursts run concurrently
// - only true clock rises advance commands
// - read at t, paired write at t+1
// - read beats start two cycles after command
// - same command on next edge ignored
module bsic_core (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  // input clock pair and dll control
  input  wire logic              k_i,
  input  wire logic              k_n_i,
  input  wire logic              dll_off_n_i,
  // command pins
  input  wire logic              rd_sel_n_i,
  input  wire logic              wr_sel_n_i,
  input  wire bsic_pkg::bsic_addr_t sa_i,
  // write data pins
  input  wire bsic_pkg::bsic_data_t d_i,
  input  wire bsic_pkg::bsic_be_t   bw_n_i,
  // read data pins
  output bsic_pkg::bsic_data_t   q_o,
  output logic                   q_oe_o,
  // status
  output logic                   ready_o,
  output logic                   dll_bypass_o,
  // array read port
  output logic                   rd_req_o,
  output bsic_pkg::bsic_addr_t   rd_addr_o,
  input  wire bsic_pkg::bsic_data_t rd_data_i,
  // array write port
  output logic                   wr_en_o,
  output bsic_pkg::bsic_addr_t   wr_addr_o,
  output bsic_pkg::bsic_data_t   wr_data_o,
  output bsic_pkg::bsic_be_t     wr_be_o
);
  import bsic_pkg::*;

  localparam int SW = `BSIC_PIN_W;

  typedef struct packed {
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic          k_prev;
    logic          kb_prev;
    logic          nop_prev;
    logic          rtake_last;
    logic          wtake_last;
    logic          slot;
    bsic_data_t    d_hold;
    bsic_be_t      bw_hold;
    bsic_data_t    q;
    logic          q_oe;
    logic          wr_en;
    bsic_addr_t    wr_addr;
    bsic_data_t    wr_data;
    bsic_be_t      wr_be;
    bsic_addr_t    last_raddr;
  } bsic_core_st_t;

  bsic_core_st_t st_ff;
  bsic_core_st_t nxt_st;
  logic [SW-1:0] pins;
  logic          k_s;
  logic          kb_s;
  logic          off_s;
  logic          rd_on;
  logic          wr_on;
  bsic_addr_t    sa_s;
  bsic_data_t    d_s;
  bsic_be_t      bw_s;
  logic          k_rise;
  logic          kb_rise;
  logic          stop;

  bsic_burst_if rbus();
  bsic_burst_if wbus();

  // every pin crosses two flops together, keeping beats aligned
  assign pins = {bw_n_i, d_i, sa_i, wr_sel_n_i, rd_sel_n_i,
                 dll_off_n_i, k_n_i, k_i};
  assign k_s   = st_ff.s2[`BSIC_PIN_K];
  assign kb_s  = st_ff.s2[`BSIC_PIN_KB];
  assign off_s = st_ff.s2[`BSIC_PIN_OFF];
  assign rd_on = ~st_ff.s2[`BSIC_PIN_RD];
  assign wr_on = ~st_ff.s2[`BSIC_PIN_WR];
  assign sa_s  = st_ff.s2[`BSIC_PIN_SA +: `BSIC_AW];
  assign d_s   = st_ff.s2[`BSIC_PIN_D +: `BSIC_DW];
  assign bw_s  = st_ff.s2[`BSIC_PIN_BW +: `BSIC_NBYTE];

  // edge detect on the synchronised clock pair
  assign k_rise  = k_s & ~st_ff.k_prev;
  assign kb_rise = kb_s & ~st_ff.kb_prev;

  // dll lock and clock stop supervision
  bsic_dll_lock u_lock (
    .sys_clk_i     (sys_clk_i),
    .rstn_i        (rstn_i),
    .k_s_i         (k_s),
    .kb_s_i        (kb_s),
    .k_rise_i      (k_rise),
    .dll_off_n_s_i (off_s),
    .ready_o       (ready_o),
    .bypass_o      (dll_bypass_o),
    .stop_o        (stop)
  );

  // read and write sequencers are separate so both can run
  assign rbus.k_rise  = k_rise;
  assign rbus.kb_rise = kb_rise;
  assign rbus.cmd     = ready_o & rd_on;
  assign rbus.base    = sa_s;
  assign wbus.k_rise  = k_rise;
  assign wbus.kb_rise = kb_rise;
  // both selects low right after a no operation drops the write
  assign wbus.cmd     = ready_o & wr_on & ~(rd_on & st_ff.nop_prev);
  assign wbus.base    = sa_s;

  bsic_burst_seq #(
    .LAT (`BSIC_RD_LAT)
  ) u_rd_seq (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .bus       (rbus)
  );

  bsic_burst_seq #(
    .LAT (`BSIC_WR_LAT)
  ) u_wr_seq (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .bus       (wbus)
  );

  // array read is combinational in the cycle of the beat
  assign rd_req_o  = rbus.beat;
  assign rd_addr_o = rbus.addr;

  assign q_o       = st_ff.q;
  assign q_oe_o    = st_ff.q_oe;
  assign wr_en_o   = st_ff.wr_en;
  assign wr_addr_o = st_ff.wr_addr;
  assign wr_data_o = st_ff.wr_data;
  assign wr_be_o   = st_ff.wr_be;

  // next state of the capture and output stages
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.s1      = pins;
    nxt_st.s2      = st_ff.s1;
    nxt_st.k_prev  = k_s;
    nxt_st.kb_prev = kb_s;
    nxt_st.slot    = k_rise | kb_rise;
    nxt_st.wr_en   = 1'b0;
    if (k_rise) begin
      nxt_st.nop_prev   = ~rd_on & ~wr_on;
      nxt_st.rtake_last = rbus.take;
      nxt_st.wtake_last = wbus.take;
    end
    // data pins sampled on both clock rises; held while stopped
    if (k_rise || kb_rise) begin
      nxt_st.d_hold  = d_s;
      nxt_st.bw_hold = bw_s;
    end
    // write beat lands one edge after the captured data
    if (wbus.beat) begin
      nxt_st.wr_en   = 1'b1;
      nxt_st.wr_addr = wbus.addr;
      nxt_st.wr_data = st_ff.d_hold;
      nxt_st.wr_be   = ~st_ff.bw_hold;
    end
    // each slot either drives a beat or floats the bus
    if (st_ff.slot) begin
      nxt_st.q_oe = rbus.beat;
      if (rbus.beat) begin
        nxt_st.q          = rd_data_i;
        nxt_st.last_raddr = rbus.addr;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_rd_cmd;
    k_rise && ready_o && rd_on && !st_ff.rtake_last |-> rbus.take;
  endproperty
  a_rd_cmd: assert property (p_rd_cmd)
    else $error("read select low was not taken");

  property p_wr_cmd;
    // the previous true clock rise may lie several cycles back
    k_rise && ready_o && wr_on && !(rd_on && st_ff.nop_prev) &&
      !st_ff.wtake_last |-> wbus.take;
  endproperty
  a_wr_cmd: assert property (p_wr_cmd)
    else $error("write select low was not taken");

  property p_not_ready;
    !ready_o |-> !rbus.take && !wbus.take;
  endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("command taken before the dll was ready");

  property p_rd_gap;
    k_rise && st_ff.rtake_last |-> !rbus.take;
  endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("read on the next edge was not ignored");

  // a write taken beside a fresh read must overlap its beats
  property p_both_run;
    (rbus.take || st_ff.rtake_last) && wbus.take |->
      ##[1:200] (rbus.beat && wbus.beat);
  endproperty
  a_both_run: assert property (p_both_run)
    else $error("concurrent commands off a true clock rise");

  property p_beat_edge;
    rbus.beat |-> ($past(k_rise) && !rbus.idx[0]) ||
                  ($past(kb_rise) && rbus.idx[0]);
  endproperty
  a_beat_edge: assert property (p_beat_edge)
    else $error("read beat on the wrong clock edge");

  property p_addr_lin;
    rbus.beat && rbus.idx != 2'h0 |->
      rbus.addr == st_ff.last_raddr + bsic_addr_t'(1'b1);
  endproperty
  a_addr_lin: assert property (p_addr_lin)
    else $error("burst address not linear");

  sequence s_rd_slot;
    st_ff.slot && rbus.beat;
  endsequence

  sequence s_q_driven;
    q_oe_o && q_o == $past(rd_data_i);
  endsequence

  property p_rd_out;
    s_rd_slot |=> s_q_driven;
  endproperty
  a_rd_out: assert property (p_rd_out)
    else $error("read beat not driven on its slot");

  property p_nop_hiz;
    st_ff.slot && !rbus.beat |=> !q_oe_o;
  endproperty
  a_nop_hiz: assert property (p_nop_hiz)
    else $error("read bus driven in an empty slot");

  property p_wr_cap;
    wbus.beat |=> wr_en_o && wr_addr_o == $past(wbus.addr) &&
                  wr_data_o == $past(st_ff.d_hold);
  endproperty
  a_wr_cap: assert property (p_wr_cap)
    else $error("write beat not captured");

  property p_stop_hold;
    stop |=> $stable(q_o) && $stable(q_oe_o);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("outputs moved while the clock was stopped");
endmodule // bsic_core

// File: tb/bsic_ctl_model.sv
module bsic_ctl_model (
  // clock
  input  wire logic            sys_clk_i,
  // pins toward the device
  output logic                 k_o,
  output logic                 k_n_o,
  output logic                 dll_off_n_o,
  output logic                 rd_sel_n_o,
  output logic                 wr_sel_n_o,
  output bsic_pkg::bsic_addr_t sa_o,
  output bsic_pkg::bsic_data_t d_o,
  output bsic_pkg::bsic_be_t   bw_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import bsic_pkg::*;
  logic run = 1'b1;
  time  t_cmd = 0;
  // defined pin levels from time zero
  initial begin
    k_o = 1'b0;
    dll_off_n_o = 1'b0;
    rd_sel_n_o = 1'b1;
    wr_sel_n_o = 1'b1;
    sa_o = '0;
    d_o = '0;
    bw_n_o = '1;
  end
  assign k_n_o = ~k_o;
  // half the system rate, so every k edge is seen
  always @(negedge sys_clk_i) begin
    if (run)
      k_o <= ~k_o;
  end
  // returns on the edge at which k falls
  task automatic k_fall();
    do @(negedge sys_clk_i); while (k_o !== 1'b1);
  endtask
  // read at t, write at t+1, late write data
  task automatic burst(input logic rd, rd2, wr0, wr,
                       input bsic_addr_t ra, wa, input bsic_data_t wd);
    k_fall();
    rd_sel_n_o <= ~rd;
    wr_sel_n_o <= ~wr0;
    sa_o <= ra;
    @(negedge sys_clk_i);
    t_cmd = $time;
    @(negedge sys_clk_i);
    rd_sel_n_o <= ~rd2;
    wr_sel_n_o <= ~wr;
    sa_o <= wa;
    repeat (2) @(negedge sys_clk_i);
    rd_sel_n_o <= 1'b1;
    wr_sel_n_o <= 1'b1;
    sa_o <= ~wa;
    // each beat changes with the clock edge that takes it
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk_i);
      d_o <= wd + 36'(i);
      bw_n_o <= 4'(i);
    end
    @(negedge sys_clk_i);
    d_o <= ~d_o;
    bw_n_o <= 4'hF;
  endtask
  // disable pin moved only while k runs steadily
  task automatic set_off(input logic v);
    @(negedge sys_clk_i);
    dll_off_n_o <= v;
  endtask
  // freeze both clocks, called only with no burst pending
  task automatic stop(input int n);
    @(negedge sys_clk_i);
    run <= 1'b0;
    repeat (n) @(negedge sys_clk_i);
    run <= 1'b1;
  endtask
endmodule // bsic_ctl_model

// File: tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bsic_pkg::*;
  // clock, reset and tallies
  logic       sys_clk = 1'b0;
  logic       rstn = 1'b0;
  int         miscompares = 0;
  int         cmp_count = 0;
  int         rcnt = 0;
  int         wcnt = 0;
  time        t_rd = 0;
  logic       rd_req_d = 1'b0;
  // device pins and array ports
  logic       k, k_n, off_n, rd_n, wr_n, q_oe, ready, byp, rd_req, wr_en;
  bsic_addr_t sa, rd_addr, wr_addr, ra_d;
  bsic_addr_t rbase = 19'h0;
  bsic_addr_t wbase = 19'h0;
  bsic_data_t d, q, rd_data, wr_data;
  bsic_data_t wd = 36'h0;
  bsic_be_t   bw_n, wr_be;

`define CHK(a, e) begin \
  cmp_count++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (e)); \
  end \
end

  always #10 sys_clk = ~sys_clk;

  // storage behind the array answers at once
  function automatic bsic_data_t mem(input bsic_addr_t a);
    return {17'h0, a} ^ 36'h5A5A5A5A5;
  endfunction
  assign rd_data = mem(rd_addr);

  bsic_ctl_model ctl (.sys_clk_i(sys_clk), .k_o(k), .k_n_o(k_n),
    .dll_off_n_o(off_n), .rd_sel_n_o(rd_n), .wr_sel_n_o(wr_n),
    .sa_o(sa), .d_o(d), .bw_n_o(bw_n));

  bsic_core DUT (.sys_clk_i(sys_clk), .rstn_i(rstn), .k_i(k),
    .k_n_i(k_n), .dll_off_n_i(off_n), .rd_sel_n_i(rd_n),
    .wr_sel_n_i(wr_n), .sa_i(sa), .d_i(d), .bw_n_i(bw_n), .q_o(q),
    .q_oe_o(q_oe), .ready_o(ready), .dll_bypass_o(byp),
    .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .wr_be_o(wr_be));

  // array strobes and read slots, judged as they happen
  always @(posedge sys_clk) begin
    if (rd_req_d === 1'b1) begin
      `CHK(q, mem(ra_d))
      `CHK(q_oe, 1'b1)
    end
    rd_req_d <= rd_req;
    ra_d <= rd_addr;
    if (rd_req === 1'b1) begin
      if (rcnt == 0)
        t_rd = $time;
      `CHK(rd_addr, bsic_addr_t'(rbase + rcnt))
      rcnt++;
    end
    if (wr_en === 1'b1) begin
      `CHK(wr_addr, bsic_addr_t'(wbase + wcnt))
      `CHK(wr_data, bsic_data_t'(wd + wcnt))
      `CHK(wr_be, ~bsic_be_t'(wcnt))
      wcnt++;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // bounded wait, so a lock that never comes still ends
  task automatic wait_ready(output int n);
    n = 0;
    while (ready !== 1'b1 && n < 6000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // disable pin low from reset: no locking wait
  task automatic t_bypass();
    tick(8);
    `CHK(ready, 1'b1)
    `CHK(byp, 1'b1)
  endtask

  // base next to a carry so the increment crosses bits
  task automatic t_read();
    rbase = 19'h1FFFE;
    rcnt = 0;
    ctl.burst(1'b1, 1'b0, 1'b0, 1'b0, rbase, 19'h0, 36'h0);
    tick(14);
    `CHK(rcnt, 4)
    `CHK((t_rd - ctl.t_cmd) inside {[140:200]}, 1'b1)
  endtask

  // selects high: read bus released every slot
  task automatic t_idle();
    rcnt = 0;
    repeat (12) begin
      tick(1);
      `CHK(q_oe, 1'b0)
    end
    `CHK(rcnt, 0)
  endtask

  // disable rise restarts locking; commands ignored meanwhile
  task automatic t_lock();
    int n;
    ctl.set_off(1'b1);
    tick(6);
    `CHK(ready, 1'b0)
    `CHK(byp, 1'b0)
    rcnt = 0;
    ctl.burst(1'b1, 1'b0, 1'b0, 1'b0, rbase, 19'h0, 36'h0);
    tick(10);
    `CHK(rcnt, 0)
    wait_ready(n);
    `CHK(n inside {[4030:4100]}, 1'b1)
  endtask

  // read at t held into t+1, write at t+1: the held read drops
  task automatic t_both();
    rbase = 19'h00100;
    wbase = 19'h7FFFC;
    wd = 36'h123456780;
    rcnt = 0;
    wcnt = 0;
    ctl.burst(1'b1, 1'b1, 1'b0, 1'b1, rbase, wbase, wd);
    tick(20);
    `CHK(rcnt, 4)
    `CHK(wcnt, 4)
  endtask

  // both selects low after a nop: the write must be ignored
  task automatic t_nop_pair();
    rbase = 19'h2AAAA;
    rcnt = 0;
    wcnt = 0;
    ctl.burst(1'b1, 1'b0, 1'b1, 1'b0, rbase, wbase, wd);
    tick(16);
    `CHK(rcnt, 4)
    `CHK(wcnt, 0)
  endtask

  // frozen clock drops lock while the read data output q keeps its state
  task automatic t_stop();
    bsic_data_t q0;
    int         n;
    q0 = q;
    ctl.stop(6);
    tick(1);
    `CHK(ready, 1'b0)
    `CHK(q, q0)
    wait_ready(n);
    `CHK(n inside {[4000:4110]}, 1'b1)
  endtask

  initial begin
    tick(10);
    @(negedge sys_clk);
    rstn = 1'b1;
    t_bypass();
    t_read();
    t_idle();
    t_lock();
    t_both();
    t_nop_pair();
    t_stop();
    results();
  end

  // tests need about 8k cycles; give them ample room before giving up
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    results();
  end
endmodule // tb_top
